// ==== src/irqm_pkg.sv ====
package irqm_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } irqm_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irqm_axil_rsp_t;

  // ****************************************
  // Source groups (also the fixed tie order)
  // ****************************************
  localparam int unsigned NGRP = 8;
  localparam int unsigned NEXT = 5;
  localparam logic [2:0] G_TMR = 3'h0;
  localparam logic [2:0] G_DMA0 = 3'h1;
  localparam logic [2:0] G_DMA1 = 3'h2;
  localparam logic [2:0] G_E0 = 3'h3;
  localparam logic [2:0] G_E1 = 3'h4;
  localparam logic [2:0] G_E2 = 3'h5;
  localparam logic [2:0] G_E3 = 3'h6;
  localparam logic [2:0] G_E4 = 3'h7;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] OFF_TIMER_IRQ_CONTROL = 8'h32;
  localparam logic [7:0] OFF_DMA_CHAN0_IRQ_CONTROL = 8'h34;
  localparam logic [7:0] OFF_DMA_CHAN1_IRQ_CONTROL = 8'h36;
  localparam logic [7:0] OFF_EXT_SOURCE0_CONTROL = 8'h38;
  localparam logic [7:0] OFF_EXT_SOURCE1_CONTROL = 8'h3a;
  localparam logic [7:0] OFF_EXT_SOURCE2_CONTROL = 8'h3c;
  localparam logic [7:0] OFF_EXT_SOURCE3_CONTROL = 8'h3e;
  localparam logic [7:0] OFF_EXT_SOURCE4_CONTROL = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_IN_SERVICE = 8'h2c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h26;
  localparam logic [7:0] CTRL_OFF [NGRP] = '{
    OFF_TIMER_IRQ_CONTROL, OFF_DMA_CHAN0_IRQ_CONTROL, OFF_DMA_CHAN1_IRQ_CONTROL,
    OFF_EXT_SOURCE0_CONTROL, OFF_EXT_SOURCE1_CONTROL, OFF_EXT_SOURCE2_CONTROL,
    OFF_EXT_SOURCE3_CONTROL, OFF_EXT_SOURCE4_CONTROL};

  // ****************************************
  // Control register fields and reset
  // ****************************************
  localparam int unsigned BIT_SPECIAL_NESTING_ENABLE = 6;
  localparam int unsigned BIT_CASC = 5;
  localparam int unsigned BIT_LTM = 4;
  localparam int unsigned BIT_MSK = 3;
  localparam int unsigned PRIO_W = 3;
  localparam logic [15:0] CTRL_RST = 16'h000f;
  localparam int unsigned STAT_PEND_BIT = 15;

  // ****************************************
  // Interrupt type codes
  // ****************************************
  localparam logic [7:0] TYPE_TMR0 = 8'h08;
  localparam logic [7:0] TYPE_TMR1 = 8'h12;
  localparam logic [7:0] TYPE_TMR2 = 8'h13;
  localparam logic [7:0] TYPE_DMA0 = 8'h0a;
  localparam logic [7:0] TYPE_DMA1 = 8'h0b;
  localparam logic [7:0] TYPE_E0 = 8'h0c;
  localparam logic [7:0] TYPE_E1 = 8'h0d;
  localparam logic [7:0] TYPE_E2 = 8'h0e;
  localparam logic [7:0] TYPE_E3 = 8'h0f;
  localparam logic [7:0] TYPE_E4 = 8'h10;
  localparam logic [7:0] GRP_TYPE [NGRP] = '{
    TYPE_TMR0, TYPE_DMA0, TYPE_DMA1, TYPE_E0, TYPE_E1, TYPE_E2, TYPE_E3, TYPE_E4};

endpackage

// ==== src/irqm_pin_sync.sv ====
`timescale 1ns/100ps
// Two-flop synchroniser with rising-edge detect on the synchronised level
module irqm_pin_sync #(
  parameter int unsigned W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } irqm_sync_st_t;

  irqm_sync_st_t s_q;
  irqm_sync_st_t s_d;

  if (W < 1) begin : g_bad_w
    $error("irqm_pin_sync: W must be at least 1");
  end

  always_comb begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync;
  assign rise = s_q.sync & ~s_q.prev;
endmodule // irqm_pin_sync

// ==== src/irqm_prio_arb.sv ====
`timescale 1ns/100ps
// Picks the requester with the smallest priority code; ties go to the lowest index
module irqm_prio_arb #(
  parameter int unsigned N = 8,
  parameter int unsigned PW = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][PW-1:0] prio,
  output logic found,
  output logic [$clog2(N)-1:0] idx
);
  logic [PW-1:0] best;

  if (N < 2 || PW < 1) begin : g_bad_cfg
    $error("irqm_prio_arb: N must be at least 2 and PW at least 1");
  end

  always_comb begin
    found = 1'b0;
    idx = '0;
    best = '1;
    for (int i = 0; i < N; i++) begin
      // Strict compare keeps the earlier index on equal codes
      if (req[i] && (!found || prio[i] < best)) begin
        found = 1'b1;
        idx = i[$clog2(N)-1:0];
        best = prio[i];
      end
    end
  end
endmodule // irqm_prio_arb

// ==== src/irqm_ctrl.sv ====
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - External sources zero and one deliver type codes 0ch and 0dh.
// - Cascade bit on source zero turns pin two into its acknowledge output.
// - Cascade bit on source one turns pin three into its acknowledge output.
// - External control registers reset to 000fh: masked, lowest priority, edge.
// - Bit 6 of sources zero and one enables special nesting; upper bits reserved.
// - Bit 5 of sources zero and one enables cascade operation.
// - Bit 4 of the external sources selects active-high level trigger; zero selects rising edge.
// - Bit 3 set masks the source; clear lets it interrupt.
// - Mask bit is one storage shared by control and mask registers.
// - Bits 2..0 give priority, 000 highest down to 111 lowest.
// - Sources two and three deliver type codes 0eh and 0fh.
// - Sources two and three have trigger, mask, priority only.
// - Source four delivers type 10h with trigger, mask, priority only.
// - Source four has no cascade acknowledge and no special nesting.
// - Timers use types 08h, 12h, 13h and share one control register.
// - DMA channels zero and one deliver types 0ah and 0bh.
// - Special nesting re-accepts its own pin while in service, still blocks lower.
module irqm_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire irqm_pkg::irqm_axil_req_t axil_req,
  output irqm_pkg::irqm_axil_rsp_t axil_rsp,
  input wire logic [2:0] timer_req,
  input wire logic [1:0] dma_req,
  input wire logic ext_request_zero,
  input wire logic ext_request_one,
  input wire logic ext_request_two_i,
  output logic ext_request_two_o,
  output logic ext_request_two_oe_n,
  input wire logic ext_request_three_i,
  output logic ext_request_three_o,
  output logic ext_request_three_oe_n,
  input wire logic ext_request_four,
  output logic irq_req,
  output logic [7:0] irq_type,
  input wire logic irq_ack
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic aw_rdy;
    logic [irqm_pkg::ADDR_W-1:0] awaddr;
    logic w_rdy;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [irqm_pkg::NGRP-1:0] msk;
    logic [irqm_pkg::NGRP-1:0][irqm_pkg::PRIO_W-1:0] pr;
    logic [irqm_pkg::NEXT-1:0] level_trigger_select;
    logic [1:0] casc;
    logic [1:0] special_nesting_enable;
    logic [irqm_pkg::NEXT-1:0] ext_pend;
    logic [irqm_pkg::NGRP-1:0] insrv;
    logic irq;
    logic [2:0] win;
    logic [7:0] typ;
    logic [1:0] ack_o;
    logic [1:0] ack_oe_n;
  } irqm_ctrl_st_t;

  irqm_ctrl_st_t s_q;
  irqm_ctrl_st_t s_d;

  logic [irqm_pkg::NEXT-1:0] ext_lvl;
  logic [irqm_pkg::NEXT-1:0] ext_rise;
  logic [irqm_pkg::NEXT-1:0] ext_req;
  logic [irqm_pkg::NGRP-1:0] grp_req;
  logic [irqm_pkg::NGRP-1:0] elig;
  wire [irqm_pkg::NGRP-1:0] hi_block [irqm_pkg::NGRP];
  logic arb_found;
  logic [2:0] arb_idx;
  logic [7:0] tmr_type;

  // ****************************************
  // Request conditioning
  // ****************************************
  irqm_pin_sync #(
    .W(irqm_pkg::NEXT)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin({ext_request_four, ext_request_three_i, ext_request_two_i, ext_request_one,
          ext_request_zero}),
    .level(ext_lvl),
    .rise(ext_rise)
  );

  // Edge mode still wants the line high when taken, so a glitch cannot linger
  assign ext_req[0] = s_q.level_trigger_select[0] ? ext_lvl[0] : (s_q.ext_pend[0] & ext_lvl[0]);
  assign ext_req[1] = s_q.level_trigger_select[1] ? ext_lvl[1] : (s_q.ext_pend[1] & ext_lvl[1]);
  assign ext_req[2] = !s_q.casc[0] &&
                      (s_q.level_trigger_select[2] ? ext_lvl[2] : (s_q.ext_pend[2] & ext_lvl[2]));
  assign ext_req[3] = !s_q.casc[1] &&
                      (s_q.level_trigger_select[3] ? ext_lvl[3] : (s_q.ext_pend[3] & ext_lvl[3]));
  assign ext_req[4] = s_q.level_trigger_select[4] ? ext_lvl[4] : (s_q.ext_pend[4] & ext_lvl[4]);
  assign grp_req = {ext_req, dma_req, |timer_req};
  // Lowest-numbered timer first when several fire together
  assign tmr_type = timer_req[0] ? irqm_pkg::TYPE_TMR0 :
                    timer_req[1] ? irqm_pkg::TYPE_TMR1 : irqm_pkg::TYPE_TMR2;

  // ****************************************
  // Nesting and masking per group
  // ****************************************
  for (genvar g = 0; g < irqm_pkg::NGRP; g++) begin : g_grp
    for (genvar j = 0; j < irqm_pkg::NGRP; j++) begin : g_other
      // Any other in-service source of equal or better code holds this one off
      assign hi_block[g][j] = (j != g) && s_q.insrv[j] && (s_q.pr[j] <= s_q.pr[g]);
    end
    localparam bit HAS_SPECIAL_NESTING_ENABLE = (g == 3) || (g == 4);
    logic own_ok;
    if (HAS_SPECIAL_NESTING_ENABLE) begin : g_sf
      assign own_ok = !s_q.insrv[g] || s_q.special_nesting_enable[g-3];
    end else begin : g_nosf
      assign own_ok = !s_q.insrv[g];
    end
    assign elig[g] = grp_req[g] && !s_q.msk[g] && own_ok && !(|hi_block[g]);
  end

  irqm_prio_arb #(
    .N(irqm_pkg::NGRP),
    .PW(irqm_pkg::PRIO_W)
  ) u_arb (
    .req(elig),
    .prio(s_q.pr),
    .found(arb_found),
    .idx(arb_idx)
  );

  // ****************************************
  // Register views
  // ****************************************
  function automatic logic [15:0] grp_to_word(input logic [7:0] g);
    return {7'h00, g[7:1], 1'b0, g[0]};
  endfunction

  function automatic logic [7:0] word_to_grp(input logic [15:0] w);
    return {w[8:2], w[0]};
  endfunction

  // Returns {hit, data}; unused bits stay zero
  function automatic logic [16:0] rd_reg(input logic [irqm_pkg::ADDR_W-1:0] a);
    logic [16:0] r;
    r = '0;
    if (a[irqm_pkg::ADDR_W-1:10] == '0) begin
      for (int g = 0; g < irqm_pkg::NGRP; g++) begin
        if (a[9:2] == irqm_pkg::CTRL_OFF[g]) begin
          r[16] = 1'b1;
          r[irqm_pkg::BIT_MSK] = s_q.msk[g];
          r[2:0] = s_q.pr[g];
          if (g >= 3) begin
            r[irqm_pkg::BIT_LTM] = s_q.level_trigger_select[g-3];
          end
          if (g == 3 || g == 4) begin
            r[irqm_pkg::BIT_CASC] = s_q.casc[g-3];
            r[irqm_pkg::BIT_SPECIAL_NESTING_ENABLE] = s_q.special_nesting_enable[g-3];
          end
        end
      end
      unique case (a[9:2])
        irqm_pkg::OFF_IRQ_MASK: r = {1'b1, grp_to_word(s_q.msk)};
        irqm_pkg::OFF_IN_SERVICE: r = {1'b1, grp_to_word(s_q.insrv)};
        irqm_pkg::OFF_IRQ_STATUS: r = {1'b1, s_q.irq, 7'h00, s_q.typ};
        default: r = r;
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic [16:0] rd_w;
  logic [16:0] rd_a;
  logic [15:0] bmask;
  logic [15:0] wval;
  logic [2:0] ew;

  always_comb begin
    s_d = s_q;
    rd_w = rd_reg(s_q.awaddr);
    rd_a = rd_reg(axil_req.araddr);
    bmask = {{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    wval = (rd_w[15:0] & ~bmask) | (s_q.wdata[15:0] & bmask);
    ew = 3'h0;
    if (axil_req.awvalid && s_q.aw_rdy) begin
      s_d.aw_rdy = 1'b0;
      s_d.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && s_q.w_rdy) begin
      s_d.w_rdy = 1'b0;
      s_d.wdata = axil_req.wdata;
      s_d.wstrb = axil_req.wstrb;
    end
    if (!s_q.aw_rdy && !s_q.w_rdy && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = rd_w[16] ? irqm_pkg::RESP_OKAY : irqm_pkg::RESP_SLVERR;
      for (int g = 0; g < irqm_pkg::NGRP; g++) begin
        if (rd_w[16] && s_q.awaddr[9:2] == irqm_pkg::CTRL_OFF[g]) begin
          s_d.msk[g] = wval[irqm_pkg::BIT_MSK];
          s_d.pr[g] = wval[2:0];
          if (g >= 3) begin
            ew = 3'(g - 3);
            s_d.level_trigger_select[ew] = wval[irqm_pkg::BIT_LTM];
          end
          // Only sources zero and one keep cascade and nesting bits
          if (g == 3 || g == 4) begin
            s_d.casc[ew[0]] = wval[irqm_pkg::BIT_CASC];
            s_d.special_nesting_enable[ew[0]] = wval[irqm_pkg::BIT_SPECIAL_NESTING_ENABLE];
          end
        end
      end
      if (rd_w[16] && s_q.awaddr[9:2] == irqm_pkg::OFF_IRQ_MASK) begin
        s_d.msk = word_to_grp(wval);
      end
      if (rd_w[16] && s_q.awaddr[9:2] == irqm_pkg::OFF_IN_SERVICE) begin
        s_d.insrv = s_q.insrv & ~word_to_grp(s_q.wdata[15:0] & bmask);
      end
    end
    if (s_q.bvalid && axil_req.bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_rdy = 1'b1;
      s_d.w_rdy = 1'b1;
    end
    if (axil_req.arvalid && s_q.ar_rdy) begin
      s_d.ar_rdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = {16'h0000, rd_a[15:0]};
      s_d.rresp = rd_a[16] ? irqm_pkg::RESP_OKAY : irqm_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && axil_req.rready) begin
      s_d.rvalid = 1'b0;
      s_d.ar_rdy = 1'b1;
    end

    // Acknowledge comes after the bus write so a hardware set beats a clear
    s_d.ack_o = 2'b11;
    if (irq_ack && s_q.irq) begin
      s_d.insrv[s_q.win] = 1'b1;
      if (s_q.win >= irqm_pkg::G_E0) begin
        s_d.ext_pend[s_q.win - irqm_pkg::G_E0] = 1'b0;
      end
      if (s_q.win == irqm_pkg::G_E0 && s_q.casc[0]) begin
        s_d.ack_o[0] = 1'b0;
      end
      if (s_q.win == irqm_pkg::G_E1 && s_q.casc[1]) begin
        s_d.ack_o[1] = 1'b0;
      end
    end
    s_d.ext_pend = s_d.ext_pend | ext_rise;
    s_d.ack_oe_n = ~s_d.casc;
    // Drop the request on acknowledge; nesting state settles a cycle later
    s_d.irq = arb_found && !irq_ack;
    s_d.win = arb_idx;
    s_d.typ = (arb_idx == irqm_pkg::G_TMR) ? tmr_type :
              irqm_pkg::GRP_TYPE[arb_idx];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
      s_q.msk <= {irqm_pkg::NGRP{irqm_pkg::CTRL_RST[irqm_pkg::BIT_MSK]}};
      s_q.pr <= {irqm_pkg::NGRP{irqm_pkg::CTRL_RST[2:0]}};
      s_q.ack_o <= 2'b11;
      s_q.ack_oe_n <= 2'b11;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign axil_rsp = '{awready: s_q.aw_rdy, wready: s_q.w_rdy, bvalid: s_q.bvalid,
                      bresp: s_q.bresp, arready: s_q.ar_rdy, rvalid: s_q.rvalid,
                      rdata: s_q.rdata, rresp: s_q.rresp};
  assign ext_request_two_o = s_q.ack_o[0];
  assign ext_request_two_oe_n = s_q.ack_oe_n[0];
  assign ext_request_three_o = s_q.ack_o[1];
  assign ext_request_three_oe_n = s_q.ack_oe_n[1];
  assign irq_req = s_q.irq;
  assign irq_type = s_q.typ;

  // ****************************************
  // Checks
  // ****************************************
  logic better;
  logic tie_lo;
  always_comb begin
    better = 1'b0;
    tie_lo = 1'b0;
    for (int j = 0; j < irqm_pkg::NGRP; j++) begin
      if (elig[j] && s_q.pr[j] < s_q.pr[arb_idx]) better = 1'b1;
      if (elig[j] && s_q.pr[j] == s_q.pr[arb_idx] && j < arb_idx) tie_lo = 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_ext0_type;
    $rose(s_q.irq) && s_q.win == irqm_pkg::G_E0 |-> s_q.typ == 8'h0c;
  endproperty
  a_ext0_type: assert property (p_ext0_type) else $error("source zero type wrong");

  property p_casc0;
    s_q.casc[0] |-> !elig[irqm_pkg::G_E2] && !s_q.ack_oe_n[0];
  endproperty
  a_casc0: assert property (p_casc0) else $error("pin two not taken for ack");

  property p_casc1;
    s_q.casc[1] |-> !elig[irqm_pkg::G_E3] && !s_q.ack_oe_n[1];
  endproperty
  a_casc1: assert property (p_casc1) else $error("pin three not taken for ack");

  property p_reset_vals;
    $past(rst) |-> s_q.msk == 8'hff && s_q.level_trigger_select == '0 && s_q.casc == '0 &&
      s_q.special_nesting_enable == '0 && s_q.pr == {8{3'h7}};
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_edge_latch;
    !s_q.level_trigger_select[0] && ext_rise[0] |=> s_q.ext_pend[0];
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");

  property p_mask;
    arb_found |-> !s_q.msk[arb_idx];
  endproperty
  a_mask: assert property (p_mask) else $error("masked source won");

  property p_prio;
    arb_found |-> !better;
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority won");

  property p_nest;
    s_q.insrv[irqm_pkg::G_E0] && !s_q.special_nesting_enable[0] |-> !elig[irqm_pkg::G_E0];
  endproperty
  a_nest: assert property (p_nest) else $error("in-service source re-entered");

  property p_tie;
    arb_found |-> !tie_lo;
  endproperty
  a_tie: assert property (p_tie) else $error("tie order broken");

  c_e0_irq: cover property (s_q.irq && s_q.win == irqm_pkg::G_E0);
  c_casc_ack: cover property (!s_q.ack_o[0]);
  c_special_nesting_enable_reentry: cover property (s_q.irq && s_q.insrv[s_q.win]);
  c_write_done: cover property (s_q.bvalid && axil_req.bready);
endmodule // irqm_ctrl

// ==== verif/irqm_ext_model.sv ====
`timescale 1ns/100ps
// Far-side requesters: a line rises on a raise pulse and holds until served
module irqm_ext_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] raise,
  input wire logic irq_ack,
  input wire logic [7:0] irq_type,
  input wire logic [1:0] casc_ack_n,
  output logic [4:0] line
);
  logic [4:0] served;
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      served[k] = irq_ack && (irq_type == irqm_pkg::GRP_TYPE[k + 3]);
    end
    served[1:0] = served[1:0] | ~casc_ack_n;
  end
  // No early release, in either trigger mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line <= 5'h00;
    end else begin
      line <= raise | (line & ~served);
    end
  end
endmodule // irqm_ext_model

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  typedef struct {logic [7:0] idx; logic [15:0] wd; logic [15:0] rd; int src;
    logic [7:0] ty;} irqm_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  irqm_pkg::irqm_axil_req_t req = '0;
  irqm_pkg::irqm_axil_rsp_t rsp;
  logic [4:0] src = 5'h00;
  logic [4:0] raise = 5'h00;
  logic [4:0] line;
  logic irq_ack = 1'b0;
  logic irq_req;
  logic [7:0] irq_type;
  logic two_o, two_oe_n, three_o, three_oe_n;
  logic [31:0] rd;
  logic [1:0] resp;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  irqm_row_t rows [10] = '{
    '{8'h32, 16'hfff0, 16'h0000, 0, 8'h08}, '{8'h32, 16'hfff0, 16'h0000, 1, 8'h12},
    '{8'h32, 16'hfff0, 16'h0000, 2, 8'h13}, '{8'h34, 16'hfff0, 16'h0000, 3, 8'h0a},
    '{8'h36, 16'hfff0, 16'h0000, 4, 8'h0b}, '{8'h38, 16'hff90, 16'h0010, 5, 8'h0c},
    '{8'h3a, 16'hff90, 16'h0010, 6, 8'h0d}, '{8'h3c, 16'hfff0, 16'h0010, 7, 8'h0e},
    '{8'h3e, 16'hfff0, 16'h0010, 8, 8'h0f}, '{8'h40, 16'hfff0, 16'h0010, 9, 8'h10}};

  // Shared pins: whoever has the enable owns the wire
  wire pin2 = two_oe_n ? line[2] : two_o;
  wire pin3 = three_oe_n ? line[3] : three_o;

  irqm_ctrl DUT (.core_clk(core_clk), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .timer_req(src[2:0]), .dma_req(src[4:3]), .ext_request_zero(line[0]),
    .ext_request_one(line[1]), .ext_request_two_i(pin2), .ext_request_two_o(two_o),
    .ext_request_two_oe_n(two_oe_n), .ext_request_three_i(pin3),
    .ext_request_three_o(three_o), .ext_request_three_oe_n(three_oe_n),
    .ext_request_four(line[4]), .irq_req(irq_req), .irq_type(irq_type), .irq_ack(irq_ack));

  irqm_ext_model ext_side (.core_clk(core_clk), .rst(rst), .raise(raise), .irq_ack(irq_ack),
    .irq_type(irq_type), .casc_ack_n({three_oe_n | three_o, two_oe_n | two_o}), .line(line));

  always #5 core_clk = ~core_clk;

  // ****************************************
  // Bus and interrupt tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Ready lines stay high between transfers so no edge sees them set and cleared
  task automatic axw(input logic [7:0] idx, input logic [15:0] d);
    req.awaddr <= {2'b00, idx, 2'b00};
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
  endtask

  task automatic axr(input logic [7:0] idx);
    req.araddr <= {2'b00, idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
  endtask

  task automatic pulse(input logic [4:0] m);
    raise <= m;
    @(posedge core_clk);
    raise <= 5'h00;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_req !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // Raising again at the ack edge keeps the far-side line high throughout
  task automatic ack(input logic [4:0] again);
    irq_ack <= 1'b1;
    raise <= again;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    raise <= 5'h00;
    src <= 5'h00;
  endtask

  task automatic serve(input logic [7:0] ty);
    wait_irq();
    `CHK("irq_req", 1'b1, irq_req)
    `CHK("irq_type", ty, irq_type)
    ack(5'h00);
    axw(8'h2c, 16'h01fd);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      axr(irqm_pkg::CTRL_OFF[i]);
      `CHK("reset ctrl", 16'h000f, rd[15:0])
    end
    axr(8'h28);
    `CHK("reset mask", 16'h01fd, rd[15:0])
    axr(8'h30);
    `CHK("unmapped resp", 2'b10, resp)
    axw(8'h30, 16'h0000);
    `CHK("unmapped wresp", 2'b10, resp)
    $display("reset test done");
    foreach (rows[i]) begin
      axw(rows[i].idx, rows[i].wd);
      `CHK("write resp", 2'b00, resp)
      axr(rows[i].idx);
      `CHK("ctrl readback", rows[i].rd, rd[15:0])
      if (rows[i].src < 5) src[rows[i].src] <= 1'b1;
      else pulse(5'h01 << (rows[i].src - 5));
      serve(rows[i].ty);
      axw(rows[i].idx, 16'h000f);
      $display("row %0d done", i);
    end
    axw(8'h28, 16'h01ed);
    axr(8'h38);
    `CHK("mask shared", 16'h0007, rd[15:0])
    axw(8'h38, 16'h000f);
    axr(8'h28);
    `CHK("mask shared", 16'h01fd, rd[15:0])
    $display("mask view test done");
    axw(8'h38, 16'h0013);
    axw(8'h3a, 16'h0012);
    pulse(5'h03);
    serve(8'h0d);
    serve(8'h0c);
    axw(8'h3c, 16'h0015);
    axw(8'h3e, 16'h0015);
    pulse(5'h0c);
    serve(8'h0e);
    serve(8'h0f);
    for (int i = 3; i < 7; i++) axw(irqm_pkg::CTRL_OFF[i], 16'h000f);
    axw(8'h40, 16'h0018);
    pulse(5'h10);
    tick(20);
    `CHK("masked", 1'b0, irq_req)
    axw(8'h40, 16'h0010);
    serve(8'h10);
    $display("priority and mask test done");
    // Line kept high across the ack: only level mode fires again
    for (int m = 0; m < 2; m++) begin
      axw(8'h40, m ? 16'h0000 : 16'h0010);
      pulse(5'h10);
      wait_irq();
      ack(5'h10);
      tick(8);
      `CHK("own pin blocked", 1'b0, irq_req)
      axw(8'h2c, 16'h01fd);
      tick(8);
      `CHK("retrigger", ~m[0], irq_req)
      if (m == 0) serve(8'h10);
    end
    axw(8'h40, 16'h000f);
    axw(8'h3a, 16'h0050);
    pulse(5'h02);
    wait_irq();
    ack(5'h02);
    tick(8);
    `CHK("nested again", 1'b1, irq_req)
    axr(8'h2c);
    `CHK("in service", 16'h0020, rd[15:0])
    axr(8'h26);
    `CHK("status", 16'h800d, rd[15:0])
    serve(8'h0d);
    axw(8'h3a, 16'h000f);
    $display("trigger and nesting test done");
    for (int k = 0; k < 2; k++) begin
      axw(k ? 8'h3a : 8'h38, 16'h0030);
      tick(2);
      `CHK("ack pin driven", 1'b0, k ? three_oe_n : two_oe_n)
      pulse(k ? 5'h02 : 5'h01);
      wait_irq();
      `CHK("cascade type", k ? 8'h0d : 8'h0c, irq_type)
      ack(5'h00);
      @(posedge core_clk);
      `CHK("ack low", 1'b0, k ? three_o : two_o)
      @(posedge core_clk);
      `CHK("ack high", 1'b1, k ? three_o : two_o)
      axw(8'h2c, 16'h01fd);
      axw(k ? 8'h3a : 8'h38, 16'h000f);
      tick(2);
      `CHK("pin released", 1'b1, k ? three_oe_n : two_oe_n)
    end
    $display("cascade test done");
    wrap_up();
  end
endmodule // tb
